// File: hdl/ctt_timer.sv
// Counter/timer with counter mode and receive time-out mode behind an APB slave.
// Functional notes
// - Counter mode counts preset down to zero, sets ready bit 3, output falls.
// - After zero the count wraps to 65365 and runs on silently.
// - Reading the count returns the live value, which may be changing.
// - Time-out mode restarts the count on each received character transfer.
// - On a transfer: stop one tick, reload preset, restart on the next tick.
// - Time-out expiry sets ready bit 3; interrupt only when mask bit 3 set.
// - A character after expiry restarts the count and clears bit 3 and interrupt.
// - Command 0xA enables time-out mode for that channel, 0xC disables it.
// - Time-out on command clears bit 3 and holds count until next character.
// - In time-out mode the start and stop commands do nothing.
// - Both channels enabled: restart on OR of transfers; software enables one.
// - Host has start, stop and read/write of both preset registers.
// - Status register shows ready bit 3 only; withdrawing time-out mode does not clear it.
// - Start copies both preset registers into the counter, except in time-out mode.
// - Stop clears ready bit 3 outside time-out mode, unless expiry sets it in the same cycle.
// - The counter is 16 bits with divisor from high and low presets.
`timescale 1ns/10ps
module ctt_timer (
    input wire logic pclk, // Bus clock, 10 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [7:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata_ff, // APB read data.
    output logic pready_ff, // APB ready.
    output logic pslverr_ff, // APB error for unmapped address.
    input wire logic rx_load_a, // Channel A character moved into its receive FIFO.
    input wire logic rx_load_b, // Channel B character moved into its receive FIFO.
    input wire logic ext_ct_clk, // External counter clock.
    output logic ct_out_ff, // Counter output.
    output logic irq_out_low_ff // Interrupt request, active low.
);
    logic tick;
    logic [7:0] count_preset_low_ff, nxt_count_preset_low;
    logic [7:0] count_preset_high_ff, nxt_count_preset_high;
    logic [7:0] interrupt_mask_reg_ff, nxt_interrupt_mask_reg;
    logic [7:0] aux_control_reg_ff, nxt_aux_control_reg;
    logic [1:0] tmo_en_ff, nxt_tmo_en;
    logic [1:0] rx_load, cmd_wr, tmo_on, tmo_off, tmo_hit;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [15:0] preset;
    ctt_pkg::ctt_state_type st_ff, nxt_st;
    logic isr_ct_ff, nxt_isr_ct;
    logic expired_ff, nxt_expired;
    logic nxt_ct_out, nxt_irq;
    logic [31:0] nxt_prdata;
    logic nxt_pready, nxt_pslverr;
    logic access, done, wr_done, mapped;
    logic start_cmd, stop_cmd, tmo_any, any_hit, set_flag;

    ctt_tick u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .ext_clk(ext_ct_clk),
        .sel_ext(aux_control_reg_ff[ctt_pkg::AUX_SRC_BIT]),
        .tick_ff(tick)
    );

    // Bus phase decode: data is prepared in the first access cycle, the transfer ends with pready.
    assign access = psel & penable & ~pready_ff;
    assign done = psel & penable & pready_ff;
    assign wr_done = done & pwrite;
    assign start_cmd = done & (paddr == ctt_pkg::OFF_START) & ~tmo_any;
    assign stop_cmd = done & (paddr == ctt_pkg::OFF_STOP) & ~tmo_any;
    assign preset = {count_preset_high_ff, count_preset_low_ff};
    assign rx_load = {rx_load_b, rx_load_a};
    assign tmo_any = |tmo_en_ff;
    assign any_hit = |tmo_hit;

    // Per-channel command decode and receive event gating.
    for (genvar i = 0; i < ctt_pkg::CHANS; i++) begin : g_chan
        assign cmd_wr[i] = wr_done & (paddr == ((i == 0) ? ctt_pkg::OFF_CMD_A : ctt_pkg::OFF_CMD_B));
        assign tmo_on[i] = cmd_wr[i] & (pwdata[ctt_pkg::CMD_MSB:ctt_pkg::CMD_LSB] == ctt_pkg::CMD_TMO_ON);
        assign tmo_off[i] = cmd_wr[i] & (pwdata[ctt_pkg::CMD_MSB:ctt_pkg::CMD_LSB] == ctt_pkg::CMD_TMO_OFF);
        assign tmo_hit[i] = rx_load[i] & tmo_en_ff[i];
    end

    // Address decode for the unmapped-address error.
    always_comb begin
        case (paddr)
            ctt_pkg::OFF_PRESET_LOW, ctt_pkg::OFF_PRESET_HIGH, ctt_pkg::OFF_CMD_A, ctt_pkg::OFF_CMD_B,
            ctt_pkg::OFF_ISR, ctt_pkg::OFF_IMR, ctt_pkg::OFF_START, ctt_pkg::OFF_STOP,
            ctt_pkg::OFF_COUNT, ctt_pkg::OFF_AUX: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Bus answer: one wait cycle, then pready with read data and error.
    always_comb begin
        nxt_pready = access;
        nxt_pslverr = access & ~mapped;
        nxt_prdata = 32'h0000_0000;
        if (access && !pwrite) begin
            case (paddr)
                ctt_pkg::OFF_PRESET_LOW: nxt_prdata = {24'h000000, count_preset_low_ff};
                ctt_pkg::OFF_PRESET_HIGH: nxt_prdata = {24'h000000, count_preset_high_ff};
                ctt_pkg::OFF_ISR: nxt_prdata = 32'(isr_ct_ff) << ctt_pkg::CT_BIT;
                ctt_pkg::OFF_IMR: nxt_prdata = {24'h000000, interrupt_mask_reg_ff};
                ctt_pkg::OFF_COUNT: nxt_prdata = {16'h0000, cnt_ff};
                ctt_pkg::OFF_AUX: nxt_prdata = {24'h000000, aux_control_reg_ff}
                    | (32'(tmo_en_ff) << ctt_pkg::AUX_TMO_LSB);
                default: nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Host-written registers and time-out enables.
    always_comb begin
        nxt_count_preset_low = count_preset_low_ff;
        nxt_count_preset_high = count_preset_high_ff;
        nxt_interrupt_mask_reg = interrupt_mask_reg_ff;
        nxt_aux_control_reg = aux_control_reg_ff;
        nxt_tmo_en = (tmo_en_ff | tmo_on) & ~tmo_off;
        if (wr_done) begin
            case (paddr)
                ctt_pkg::OFF_PRESET_LOW: nxt_count_preset_low = pwdata[7:0];
                ctt_pkg::OFF_PRESET_HIGH: nxt_count_preset_high = pwdata[7:0];
                ctt_pkg::OFF_IMR: nxt_interrupt_mask_reg = pwdata[7:0];
                ctt_pkg::OFF_AUX: nxt_aux_control_reg = pwdata[7:0];
                default: nxt_aux_control_reg = aux_control_reg_ff;
            endcase
        end
    end

    // Counter sequencing: start/stop commands, receive restarts, down-count with wrap.
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_expired = expired_ff;
        nxt_ct_out = ct_out_ff;
        set_flag = 1'b0;
        case (st_ff)
            ctt_pkg::ST_RUN: begin
                if (tick) begin
                    if (cnt_ff == ctt_pkg::CNT_RST) begin
                        nxt_cnt = ctt_pkg::WRAP_VALUE;
                    end else begin
                        nxt_cnt = cnt_ff - 16'h0001;
                        if ((cnt_ff == 16'h0001) && !expired_ff) begin
                            set_flag = 1'b1;
                            nxt_expired = 1'b1;
                            nxt_ct_out = 1'b0;
                        end
                    end
                end
            end
            ctt_pkg::ST_HOLD: begin
                if (tick) begin
                    nxt_st = ctt_pkg::ST_LOAD;
                end
            end
            ctt_pkg::ST_LOAD: begin
                if (tick) begin
                    nxt_cnt = preset;
                    nxt_st = ctt_pkg::ST_RUN;
                end
            end
            ctt_pkg::ST_IDLE: nxt_st = ctt_pkg::ST_IDLE;
            default: nxt_st = ctt_pkg::ST_IDLE;
        endcase
        if (start_cmd) begin
            nxt_cnt = preset;
            nxt_st = ctt_pkg::ST_RUN;
            nxt_expired = 1'b0;
            nxt_ct_out = 1'b1;
        end
        if (stop_cmd) begin
            nxt_st = ctt_pkg::ST_IDLE;
        end
        if (|tmo_on) begin
            nxt_st = ctt_pkg::ST_IDLE;
        end
        if (any_hit) begin
            nxt_st = ctt_pkg::ST_HOLD;
            nxt_expired = 1'b0;
            nxt_ct_out = 1'b1;
        end
    end

    // Ready flag: expiry wins over any clear in the same cycle.
    always_comb begin
        nxt_isr_ct = isr_ct_ff;
        if (stop_cmd || (|tmo_on) || any_hit) begin
            nxt_isr_ct = 1'b0;
        end
        if (set_flag) begin
            nxt_isr_ct = 1'b1;
        end
        nxt_irq = ~(isr_ct_ff & interrupt_mask_reg_ff[ctt_pkg::CT_BIT]);
    end

    // Registers every state group.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            count_preset_low_ff <= ctt_pkg::REG_RST;
            count_preset_high_ff <= ctt_pkg::REG_RST;
            interrupt_mask_reg_ff <= ctt_pkg::REG_RST;
            aux_control_reg_ff <= ctt_pkg::REG_RST;
            tmo_en_ff <= 2'h0;
            st_ff <= ctt_pkg::ST_IDLE;
            cnt_ff <= ctt_pkg::CNT_RST;
            expired_ff <= 1'b0;
            ct_out_ff <= 1'b1;
            isr_ct_ff <= 1'b0;
            irq_out_low_ff <= 1'b1;
        end else begin
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            count_preset_low_ff <= nxt_count_preset_low;
            count_preset_high_ff <= nxt_count_preset_high;
            interrupt_mask_reg_ff <= nxt_interrupt_mask_reg;
            aux_control_reg_ff <= nxt_aux_control_reg;
            tmo_en_ff <= nxt_tmo_en;
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            expired_ff <= nxt_expired;
            ct_out_ff <= nxt_ct_out;
            isr_ct_ff <= nxt_isr_ct;
            irq_out_low_ff <= nxt_irq;
        end
    end

    // Checks on the counter, flag and command behaviour.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_expiry_flag: assert property (st_ff == ctt_pkg::ST_RUN && tick && cnt_ff == 16'h0001 && !expired_ff
        && !start_cmd && !any_hit |=> isr_ct_ff && !ct_out_ff)
        else $error("Expiry did not set flag and drop output.");
    a_wrap_value: assert property (st_ff == ctt_pkg::ST_RUN && tick && cnt_ff == ctt_pkg::CNT_RST && !start_cmd
        && !any_hit |=> cnt_ff == ctt_pkg::WRAP_VALUE) else $error("Counter did not wrap to 65365.");
    a_live_read: assert property (access && !pwrite && paddr == ctt_pkg::OFF_COUNT
        |=> pready_ff && prdata_ff[15:0] == $past(cnt_ff)) else $error("Count read is not live.");
    a_rx_restart: assert property (any_hit && !set_flag |=> st_ff == ctt_pkg::ST_HOLD && !isr_ct_ff)
        else $error("Receive transfer did not restart and clear.");
    a_reload_seq: assert property (st_ff == ctt_pkg::ST_LOAD && tick && !any_hit && !(|tmo_on) && !stop_cmd
        |=> st_ff == ctt_pkg::ST_RUN && cnt_ff == $past(preset)) else $error("Reload sequence wrong.");
    a_irq_masked: assert property (isr_ct_ff && interrupt_mask_reg_ff[ctt_pkg::CT_BIT]
        |=> !irq_out_low_ff) else $error("Masked-in flag gave no interrupt.");
    a_irq_gated: assert property (!interrupt_mask_reg_ff[ctt_pkg::CT_BIT] |=> irq_out_low_ff)
        else $error("Interrupt raised while masked.");
    a_tmo_enable: assert property (tmo_on[0] && !tmo_off[0] |=> tmo_en_ff[0])
        else $error("Time-out on command ignored.");
    a_tmo_on_hold: assert property (|tmo_on && !any_hit && !set_flag |=> st_ff == ctt_pkg::ST_IDLE && !isr_ct_ff)
        else $error("Time-out on did not stop and clear.");
    a_start_blocked: assert property (tmo_any && done && paddr == ctt_pkg::OFF_START && st_ff == ctt_pkg::ST_IDLE
        && !any_hit |=> st_ff == ctt_pkg::ST_IDLE) else $error("Start acted in time-out mode.");
    a_start_loads: assert property (start_cmd && !any_hit
        |=> st_ff == ctt_pkg::ST_RUN && cnt_ff == $past(preset)) else $error("Start did not load preset.");
    a_stop_clears: assert property (stop_cmd && !set_flag |=> !isr_ct_ff)
        else $error("Stop did not clear flag.");

    c_count_expiry: cover property (st_ff == ctt_pkg::ST_RUN && set_flag);
    c_rx_after_expiry: cover property (isr_ct_ff && any_hit);
    c_both_channels: cover property (tmo_en_ff == 2'h3 && any_hit);
    c_bad_address: cover property (done && pslverr_ff);
endmodule : ctt_timer

// File: hdl/ctt_pkg.sv
// Package with register map, command codes, field positions and timing for the counter/timer block.
package ctt_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int REG_W = 8;
    localparam int CHANS = 2;
    // Register byte addresses.
    localparam logic [7:0] OFF_PRESET_LOW = 8'h00;
    localparam logic [7:0] OFF_PRESET_HIGH = 8'h04;
    localparam logic [7:0] OFF_CMD_A = 8'h08;
    localparam logic [7:0] OFF_CMD_B = 8'h0C;
    localparam logic [7:0] OFF_ISR = 8'h10;
    localparam logic [7:0] OFF_IMR = 8'h14;
    localparam logic [7:0] OFF_START = 8'h18;
    localparam logic [7:0] OFF_STOP = 8'h1C;
    localparam logic [7:0] OFF_COUNT = 8'h20;
    localparam logic [7:0] OFF_AUX = 8'h24;
    // Field positions.
    localparam int CT_BIT = 3;
    localparam int CMD_LSB = 4;
    localparam int CMD_MSB = 7;
    localparam int AUX_SRC_BIT = 0;
    localparam int AUX_TMO_LSB = 4;
    // Command codes and reset values.
    localparam logic [3:0] CMD_TMO_ON = 4'hA;
    localparam logic [3:0] CMD_TMO_OFF = 4'hC;
    localparam logic [15:0] WRAP_VALUE = 16'hFF55;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [7:0] REG_RST = 8'h00;
    // Internal counter clock period and its cycle count at the bus clock.
    localparam int CLK_PERIOD_NS = 100;
    localparam int CT_TICK_NS = 400;
    localparam int TICK_CYC = CT_TICK_NS / CLK_PERIOD_NS;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD, ST_LOAD} ctt_state_type;
endpackage : ctt_pkg

// File: hdl/ctt_tick.sv
// Counter clock enable: internal prescaler or synchronised external clock edge.
`timescale 1ns/10ps
module ctt_tick (
    input wire logic pclk, // Bus clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic ext_clk, // External counter clock level.
    input wire logic sel_ext, // High selects the external clock.
    output logic tick_ff // One-cycle counter clock enable.
);
    logic s1_ff, s2_ff, s3_ff;
    logic [15:0] pre_ff, nxt_pre;
    logic nxt_tick;

    // Prescaler wraps every TICK_CYC cycles; an external rising edge is taken after two sync stages.
    always_comb begin
        nxt_pre = pre_ff + 16'h0001;
        if (pre_ff == 16'(ctt_pkg::TICK_CYC - 1)) begin
            nxt_pre = 16'h0000;
        end
        if (sel_ext) begin
            nxt_tick = s2_ff & ~s3_ff;
        end else begin
            nxt_tick = (pre_ff == 16'(ctt_pkg::TICK_CYC - 1));
        end
    end

    // Registers the synchroniser, the prescaler and the enable.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            pre_ff <= 16'h0000;
            tick_ff <= 1'b0;
        end else begin
            s1_ff <= ext_clk;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            pre_ff <= nxt_pre;
            tick_ff <= nxt_tick;
        end
    end
endmodule : ctt_tick

// File: verification/ctt_rx_model.sv
// Model of the receivers and the external clock source that feed the counter/timer.
`timescale 1ns/10ps
module ctt_rx_model (
    input wire logic pclk, // Bus clock.
    output logic rx_load_a, // Channel A character moved into its FIFO.
    output logic rx_load_b, // Channel B character moved into its FIFO.
    output logic ext_ct_clk // External counter clock, idle low.
);
    // Lines rest low until a character or a clock burst is asked for.
    initial begin
        rx_load_a = 1'b0;
        rx_load_b = 1'b0;
        ext_ct_clk = 1'b0;
    end

    // A receiver marks each character it moves into its FIFO with a one-cycle pulse.
    task automatic send(input int ch);
        @(posedge pclk);
        if (ch == 0) begin
            rx_load_a <= 1'b1;
        end else begin
            rx_load_b <= 1'b1;
        end
        @(posedge pclk);
        rx_load_a <= 1'b0;
        rx_load_b <= 1'b0;
    endtask : send

    // A burst of external clock periods; the clock stands still outside a burst.
    task automatic ext_pulses(input int cnt, input int half);
        repeat (cnt) begin
            repeat (half) @(posedge pclk);
            ext_ct_clk <= 1'b1;
            repeat (half) @(posedge pclk);
            ext_ct_clk <= 1'b0;
        end
    endtask : ext_pulses
endmodule : ctt_rx_model

// File: verification/tb_ctt_timer.sv
// Self-checking testbench for the counter/timer with receive time-out mode.
`timescale 1ns/10ps
module tb_ctt_timer;
    logic pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff, er;
    logic rx_load_a, rx_load_b, ext_ct_clk, ct_out_ff, irq_out_low_ff;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata_ff, rd, c1;
    int pre;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    int n;
    localparam int TK = ctt_pkg::TICK_CYC;

    ctt_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
        .pslverr_ff(pslverr_ff), .rx_load_a(rx_load_a), .rx_load_b(rx_load_b),
        .ext_ct_clk(ext_ct_clk), .ct_out_ff(ct_out_ff), .irq_out_low_ff(irq_out_low_ff));
    ctt_rx_model i_rx (.pclk(pclk), .rx_load_a(rx_load_a), .rx_load_b(rx_load_b), .ext_ct_clk(ext_ct_clk));

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    // Compares a seen value with the expected one.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; read data and error are taken at the edge where pready is high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Waits for the answer; only the bench timeout ends a hang here.
        do begin
            @(posedge pclk);
        end while (pready_ff !== 1'b1);
        rd = prdata_ff;
        er = pslverr_ff;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Reads a register and compares it.
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    // Waits, within a limit, for the counter output to reach a level; n holds the cycles.
    task automatic wait_out(input logic lv, input int lim);
        n = 0;
        while (ct_out_ff !== lv && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_out

    // Bus clock of 10 MHz.
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Cuts a hang short.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    // Main sequence.
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        void'($urandom(12));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(ct_out_ff), 32'h1);
        rdchk(ctt_pkg::OFF_PRESET_LOW, 32'h0);
        rdchk(ctt_pkg::OFF_PRESET_HIGH, 32'h0);
        rdchk(ctt_pkg::OFF_ISR, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        // Counter mode with a preset of one, then random ones.
        for (int t = 0; t < 3; t++) begin
            pre = (t == 0) ? 1 : int'(3 + $urandom % 8);
            apb(1'b1, ctt_pkg::OFF_PRESET_LOW, {24'h0, pre[7:0]});
            apb(1'b1, ctt_pkg::OFF_PRESET_HIGH, {24'h0, pre[15:8]});
            rdchk(ctt_pkg::OFF_PRESET_LOW, {24'h0, pre[7:0]});
            apb(1'b1, ctt_pkg::OFF_START, 32'h0);
            wait_out(1'b0, 200);
            chk(32'(n >= (pre - 1) * TK - 1 && n <= pre * TK + 2), 32'h1);
            rdchk(ctt_pkg::OFF_ISR, 32'h8);
            apb(1'b0, ctt_pkg::OFF_COUNT, 32'h0);
            c1 = rd;
            chk(32'(c1 <= 32'hFF55 && c1 >= 32'hFF52), 32'h1);
            repeat (3 * TK) @(posedge pclk);
            apb(1'b0, ctt_pkg::OFF_COUNT, 32'h0);
            chk(32'(rd < c1 && rd >= c1 - 5), 32'h1);
            chk(32'(ct_out_ff), 32'h0);
            if (t < 2) begin
                apb(1'b1, ctt_pkg::OFF_STOP, 32'h0);
                rdchk(ctt_pkg::OFF_ISR, 32'h0);
            end
        end
        // Mask gates the interrupt; time-out on clears the flag and holds the count.
        apb(1'b1, ctt_pkg::OFF_IMR, 32'h8);
        @(posedge pclk);
        chk(32'(irq_out_low_ff), 32'h0);
        apb(1'b1, ctt_pkg::OFF_CMD_A, 32'hA0);
        rdchk(ctt_pkg::OFF_ISR, 32'h0);
        rdchk(ctt_pkg::OFF_AUX, 32'h10);
        chk(32'(irq_out_low_ff), 32'h1);
        apb(1'b0, ctt_pkg::OFF_COUNT, 32'h0);
        c1 = rd;
        apb(1'b1, ctt_pkg::OFF_START, 32'h0);
        repeat (3 * TK) @(posedge pclk);
        rdchk(ctt_pkg::OFF_COUNT, c1);
        i_rx.send(0);
        // The output is high again by the edge after the one that takes the character.
        @(posedge pclk);
        chk(32'(ct_out_ff), 32'h1);
        wait_out(1'b0, 200);
        chk(32'(n >= pre * TK - 2 && n <= (pre + 2) * TK + 3), 32'h1);
        repeat (2) @(posedge pclk);
        chk(32'(irq_out_low_ff), 32'h0);
        apb(1'b1, ctt_pkg::OFF_STOP, 32'h0);
        rdchk(ctt_pkg::OFF_ISR, 32'h8);
        i_rx.send(0);
        repeat (2) @(posedge pclk);
        chk({30'h0, irq_out_low_ff, ct_out_ff}, 32'h3);
        rdchk(ctt_pkg::OFF_ISR, 32'h0);
        // Both channels on: either receiver keeps the count from expiring.
        apb(1'b1, ctt_pkg::OFF_CMD_B, 32'hA0);
        rdchk(ctt_pkg::OFF_AUX, 32'h30);
        for (int t = 0; t < 6; t++) begin
            i_rx.send(t % 2);
            repeat ((pre - 1) * TK) @(posedge pclk);
            chk(32'(ct_out_ff), 32'h1);
        end
        wait_out(1'b0, 200);
        chk(32'(n <= (pre + 2) * TK), 32'h1);
        apb(1'b1, ctt_pkg::OFF_CMD_A, 32'hC0);
        apb(1'b1, ctt_pkg::OFF_CMD_B, 32'hC0);
        rdchk(ctt_pkg::OFF_AUX, 32'h0);
        i_rx.send(1);
        rdchk(ctt_pkg::OFF_ISR, 32'h8);
        apb(1'b1, ctt_pkg::OFF_STOP, 32'h0);
        rdchk(ctt_pkg::OFF_ISR, 32'h0);
        // External counter clock: no ticks while it stands still.
        apb(1'b1, ctt_pkg::OFF_AUX, 32'h1);
        apb(1'b1, ctt_pkg::OFF_START, 32'h0);
        repeat (6 * TK) @(posedge pclk);
        chk(32'(ct_out_ff), 32'h1);
        i_rx.ext_pulses(pre, 3);
        wait_out(1'b0, 20);
        chk(32'(ct_out_ff), 32'h0);
        report_and_stop();
    end
endmodule : tb_ctt_timer
